// File: exec_pkg.sv
// Shared constants and types for the instruction execution slice
package exec_pkg;
  // Register byte offsets
  localparam logic [11:0] off_instr = 12'h000;
  localparam logic [11:0] off_status = 12'h004;
  localparam logic [11:0] off_acc = 12'h008;
  localparam logic [11:0] off_pc = 12'h00c;
  localparam logic [11:0] off_page_latch = 12'h010;
  localparam logic [11:0] off_stack_top = 12'h014;
  localparam logic [11:0] off_file_base = 12'h200;
  localparam logic [11:0] off_file_last = 12'h3fc;
  // Status register fields
  localparam int status_c_bit = 0;
  localparam int status_dc_bit = 1;
  localparam int status_z_bit = 2;
  localparam int status_busy_bit = 8;
  localparam int status_skip_bit = 9;
  localparam int status_unsup_bit = 10;
  // Stack top register fields
  localparam int stack_depth_lsb = 16;
  // Reset values
  localparam logic [7:0] acc_reset = 8'h00;
  localparam logic [12:0] pc_reset = 13'h0000;
  localparam logic [4:0] page_latch_reset = 5'h00;
  localparam logic [13:0] instr_reset = 14'h0000;
  // Instruction cycle length in pclk cycles
  localparam int tcy_pclk = 4;
  // Opcode fields
  localparam logic [5:0] opc_add_acc_to_file = 6'h07;
  localparam logic [5:0] opc_and_acc_with_file = 6'h05;
  localparam logic [3:0] opc_bit_clear = 4'h4;
  localparam logic [3:0] opc_bit_set = 4'h5;
  localparam logic [3:0] opc_skip_if_bit_zero = 4'h6;
  localparam logic [3:0] opc_skip_if_bit_one = 4'h7;
  localparam logic [4:0] opc_add_immediate = 5'h1f;
  localparam logic [5:0] opc_and_immediate = 6'h39;
  localparam logic [2:0] opc_call = 3'h4;
  localparam int page_hi_bit = 4;
  localparam int page_lo_bit = 3;
  localparam int stack_depth = 8;

  typedef enum logic [1:0] {alu_add, alu_and, alu_bclr, alu_bset} alu_op_t;
endpackage : exec_pkg

// File: exec_alu.sv
// Arithmetic, logic and bit unit with status flag generation
`timescale 1ns/1ps
module exec_alu
  import exec_pkg::*;
(
  // Operation
  input wire alu_op_t op,
  input wire logic [2:0] bit_sel,
  // Operands
  input wire logic [7:0] acc,
  input wire logic [7:0] operand,
  // Results
  output logic [7:0] result,
  output logic carry,
  output logic nibble_carry_flag,
  output logic zero
);
  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb begin
    sum = {1'b0, acc} + {1'b0, operand};
    low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
    case (op)
      alu_add: result = sum[7:0];
      alu_and: result = acc & operand;
      alu_bclr: result = operand & ~(8'h01 << bit_sel);
      default: result = operand | (8'h01 << bit_sel);
    endcase
    carry = sum[8];
    nibble_carry_flag = low_sum[4];
    zero = (result == 8'h00);
  end
endmodule : exec_alu

// File: instr_exec.sv
// Executes add, and, bit and call instructions issued over APB
// What this block does
// - Add immediate to accumulator, flags C DC Z
// - Add file register to accumulator, flags, destination
// - Destination bit 0 accumulator, 1 file
// - And immediate into accumulator, zero flag only
// - And file register, destination select, zero only
// - Bit clear leaves other bits, flags alone
// - Bit set leaves other bits, flags alone
// - Skip next if tested bit is one
// - Skip next if tested bit is zero
// - Call pushes program counter plus one
// - Call loads target and page latch bits
// - Call takes two cycles, holding off the bus in a flush cycle
// - Program counter change or skip costs cycle
`timescale 1ns/1ps
module instr_exec
  import exec_pkg::*;
#(
  parameter int tcy_div = tcy_pclk
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {st_idle, st_exec, st_flush} exec_state_t;

  exec_state_t state_q;
  logic [7:0] file_mem [0:127];
  logic [7:0] acc_q;
  logic carry_q;
  logic nibble_carry_flag_q;
  logic zero_q;
  logic unsup_q;
  logic discard_q;
  logic [12:0] pc_q;
  logic [4:0] program_page_latch_q;
  logic [13:0] instr_q;
  logic [12:0] stack_mem [0:stack_depth-1];
  logic [2:0] sp_q;
  logic [3:0] depth_q;
  logic [7:0] div_q;
  logic tcy_en;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Decoded instruction
  logic [6:0] f_addr;
  logic [2:0] bit_sel;
  logic dest_file;
  logic [7:0] imm;
  logic [10:0] target;
  logic [7:0] f_val;
  logic is_add_file;
  logic is_and_file;
  logic is_bclr;
  logic is_bset;
  logic is_skip_zero;
  logic is_skip_one;
  logic is_add_imm;
  logic is_and_imm;
  logic is_call;
  logic supported;
  logic skip_taken;
  alu_op_t alu_op;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic do_exec;
  logic bus_wr;
  logic bus_rd_take;
  logic [31:0] rd_val;
  logic mapped;

  function automatic logic is_file_addr(input logic [11:0] a);
    is_file_addr = (a >= off_file_base) && (a <= off_file_last) && (a[1:0] == 2'b00);
  endfunction : is_file_addr

  function automatic logic [6:0] file_index(input logic [11:0] a);
    file_index = a[8:2];
  endfunction : file_index

  // Instruction cycle enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
    end else if (div_q == 8'(tcy_div - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign tcy_en = (div_q == 8'(tcy_div - 1));

  // Field extraction and opcode decode
  always_comb begin
    f_addr = instr_q[6:0];
    bit_sel = instr_q[9:7];
    dest_file = instr_q[7];
    imm = instr_q[7:0];
    target = instr_q[10:0];
    f_val = file_mem[instr_q[6:0]];
    is_add_file = (instr_q[13:8] == opc_add_acc_to_file);
    is_and_file = (instr_q[13:8] == opc_and_acc_with_file);
    is_bclr = (instr_q[13:10] == opc_bit_clear);
    is_bset = (instr_q[13:10] == opc_bit_set);
    is_skip_zero = (instr_q[13:10] == opc_skip_if_bit_zero);
    is_skip_one = (instr_q[13:10] == opc_skip_if_bit_one);
    is_add_imm = (instr_q[13:9] == opc_add_immediate);
    is_and_imm = (instr_q[13:8] == opc_and_immediate);
    is_call = (instr_q[13:11] == opc_call);
    supported = is_add_file | is_and_file | is_bclr | is_bset | is_skip_zero |
                is_skip_one | is_add_imm | is_and_imm | is_call;
    skip_taken = (is_skip_one & f_val[bit_sel]) |
                 (is_skip_zero & ~f_val[bit_sel]);
    if (is_add_file || is_add_imm) begin
      alu_op = alu_add;
    end else if (is_and_file || is_and_imm) begin
      alu_op = alu_and;
    end else if (is_bclr) begin
      alu_op = alu_bclr;
    end else begin
      alu_op = alu_bset;
    end
    alu_b = (is_add_imm || is_and_imm) ? imm : f_val;
  end

  exec_alu u_alu (
    .op(alu_op),
    .bit_sel(bit_sel),
    .acc(acc_q),
    .operand(alu_b),
    .result(alu_res),
    .carry(alu_c),
    .nibble_carry_flag(alu_dc),
    .zero(alu_z)
  );

  // An instruction that follows a taken skip runs as a no-operation
  assign do_exec = (state_q == st_exec) && tcy_en && !discard_q;
  assign bus_wr = psel && penable && pready_q && pwrite;
  assign bus_rd_take = psel && penable && !pready_q && (state_q == st_idle);

  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
    end else begin
      case (state_q)
        st_idle: begin
          if (bus_wr && paddr == off_instr) begin
            state_q <= st_exec;
          end
        end
        st_exec: begin
          if (tcy_en) begin
            state_q <= (do_exec && is_call) ? st_flush : st_idle;
          end
        end
        default: begin
          if (tcy_en) begin
            state_q <= st_idle;
          end
        end
      endcase
    end
  end

  // Issued instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= instr_reset;
    end else if (bus_wr && paddr == off_instr) begin
      instr_q <= pwdata[13:0];
    end
  end

  // Skip carried into the next issued instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discard_q <= 1'b0;
    end else if (state_q == st_exec && tcy_en) begin
      discard_q <= !discard_q && skip_taken;
    end
  end

  // Accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= acc_reset;
    end else if (do_exec && (is_add_imm || is_and_imm)) begin
      acc_q <= alu_res;
    end else if (do_exec && (is_add_file || is_and_file) && !dest_file) begin
      acc_q <= alu_res;
    end else if (bus_wr && paddr == off_acc) begin
      acc_q <= pwdata[7:0];
    end
  end

  // File registers
  always_ff @(posedge pclk) begin
    if (do_exec && ((is_add_file || is_and_file) && dest_file)) begin
      file_mem[f_addr] <= alu_res;
    end else if (do_exec && (is_bclr || is_bset)) begin
      file_mem[f_addr] <= alu_res;
    end else if (bus_wr && is_file_addr(paddr)) begin
      file_mem[file_index(paddr)] <= pwdata[7:0];
    end
  end

  // Carry and nibble carry change only on additions and status register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_q <= 1'b0;
      nibble_carry_flag_q <= 1'b0;
    end else if (do_exec && (is_add_imm || is_add_file)) begin
      carry_q <= alu_c;
      nibble_carry_flag_q <= alu_dc;
    end else if (bus_wr && paddr == off_status) begin
      carry_q <= pwdata[status_c_bit];
      nibble_carry_flag_q <= pwdata[status_dc_bit];
    end
  end

  // Zero flag changes on adds, ands and status register writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_q <= 1'b0;
    end else if (do_exec && (is_add_imm || is_add_file || is_and_imm || is_and_file)) begin
      zero_q <= alu_z;
    end else if (bus_wr && paddr == off_status) begin
      zero_q <= pwdata[status_z_bit];
    end
  end

  // Unsupported opcode flag, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unsup_q <= 1'b0;
    end else if (do_exec && !supported) begin
      unsup_q <= 1'b1;
    end else if (bus_wr && paddr == off_status && pwdata[status_unsup_bit]) begin
      unsup_q <= 1'b0;
    end
  end

  // Program counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= pc_reset;
    end else if (do_exec && is_call) begin
      pc_q <= {program_page_latch_q[page_hi_bit:page_lo_bit], target};
    end else if (state_q == st_exec && tcy_en) begin
      pc_q <= pc_q + 13'h0001;
    end else if (bus_wr && paddr == off_pc) begin
      pc_q <= pwdata[12:0];
    end
  end

  // Page latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_page_latch_q <= page_latch_reset;
    end else if (bus_wr && paddr == off_page_latch) begin
      program_page_latch_q <= pwdata[4:0];
    end
  end

  // Return stack, circular, overwrites the oldest entry when full
  always_ff @(posedge pclk) begin
    if (do_exec && is_call) begin
      stack_mem[sp_q] <= pc_q + 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_q <= 3'h0;
      depth_q <= 4'h0;
    end else if (do_exec && is_call) begin
      sp_q <= sp_q + 3'h1;
      if (depth_q != 4'(stack_depth)) begin
        depth_q <= depth_q + 4'h1;
      end
    end
  end

  // Read multiplexer
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == off_instr) begin
      rd_val[13:0] = instr_q;
    end else if (paddr == off_status) begin
      rd_val[status_c_bit] = carry_q;
      rd_val[status_dc_bit] = nibble_carry_flag_q;
      rd_val[status_z_bit] = zero_q;
      rd_val[status_busy_bit] = (state_q != st_idle);
      rd_val[status_skip_bit] = discard_q;
      rd_val[status_unsup_bit] = unsup_q;
    end else if (paddr == off_acc) begin
      rd_val[7:0] = acc_q;
    end else if (paddr == off_pc) begin
      rd_val[12:0] = pc_q;
    end else if (paddr == off_page_latch) begin
      rd_val[4:0] = program_page_latch_q;
    end else if (paddr == off_stack_top) begin
      rd_val[12:0] = stack_mem[sp_q - 3'h1];
      rd_val[stack_depth_lsb +: 4] = depth_q;
    end else if (is_file_addr(paddr)) begin
      rd_val[7:0] = file_mem[file_index(paddr)];
    end else begin
      mapped = 1'b0;
    end
  end

  // Bus answer: one wait state, held off while an instruction runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= bus_rd_take;
      pslverr_q <= bus_rd_take && !mapped;
      if (bus_rd_take && !pwrite) begin
        prdata_q <= (depth_q == 4'h0 && paddr == off_stack_top) ? 32'h0000_0000 : rd_val;
      end
    end
  end

  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;
endmodule : instr_exec

// File: instr_exec_monitor.sv
// Bus protocol checker for the instruction execution slice
`timescale 1ns/1ps
module instr_exec_monitor
  import exec_pkg::*;
#(
  parameter int tcy_div = tcy_pclk
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic in_map;
  assign in_map = (paddr <= off_stack_top) || (paddr >= off_file_base && paddr <= off_file_last);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // First cycle of an access phase
  sequence s_access_start;
    psel && penable && !$past(penable);
  endsequence
  property p_answer_bound;
    s_access_start |-> ##[1:30] pready;
  endproperty
  property p_wait_state;
    s_access_start |-> !pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_ready_in_access;
    pready |-> psel && penable;
  endproperty
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  property p_map_err;
    pready && paddr[1:0] == 2'b00 |-> pslverr == !in_map;
  endproperty
  property p_err_read_zero;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  property p_prdata_hold;
    !pready |-> $stable(prdata);
  endproperty
  a_answer_bound: assert property (p_answer_bound)
    else $error("access not answered in time");
  a_wait_state: assert property (p_wait_state)
    else $error("answer without wait state");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready longer than one cycle");
  a_ready_in_access: assert property (p_ready_in_access)
    else $error("ready outside access phase");
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error without ready");
  a_map_err: assert property (p_map_err)
    else $error("error flag wrong for address");
  a_err_read_zero: assert property (p_err_read_zero)
    else $error("unmapped read data not zero");
  a_prdata_hold: assert property (p_prdata_hold)
    else $error("read data changed while idle");
endmodule : instr_exec_monitor

bind instr_exec instr_exec_monitor #(.tcy_div(tcy_div)) instr_exec_monitor_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// File: instr_exec_test.sv
// Self-checking bench for the instruction execution slice
`timescale 1ns/1ps
module instr_exec_test;
  import exec_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic err;
  logic [7:0] v;
  logic [2:0] bsel [4] = '{3'd0, 3'd1, 3'd7, 3'd6};
  logic skp [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  int mismatches = 0;
  int checked = 0;
  always #2 pclk = ~pclk;
  instr_exec #(.tcy_div(2)) instr_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      mismatches++;
      give_verdict();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic ex(input logic [13:0] op);
    apb(1'b1, off_instr, {18'h0, op});
  endtask : ex
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask : rdc
  task automatic st(input logic [2:0] e);
    apb(1'b0, off_status, 32'h0);
    check({29'h0, rd[2:0]}, {29'h0, e});
  endtask : st
  function automatic logic [11:0] fa(input logic [6:0] f);
    return off_file_base + {3'b000, f, 2'b00};
  endfunction : fa
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(off_acc, 32'h0);
    rdc(off_pc, 32'h0);
    rdc(off_stack_top, 32'h0);
    $display("reset test done");
    wr(off_acc, 32'h0f);
    ex({opc_add_immediate, 1'b0, 8'h01});
    rdc(off_acc, 32'h10);
    st(3'b010);
    wr(off_acc, 32'hff);
    ex({opc_add_immediate, 1'b0, 8'h01});
    rdc(off_acc, 32'h00);
    st(3'b111);
    wr(off_acc, 32'h70);
    ex({opc_add_immediate, 1'b0, 8'h90});
    st(3'b101);
    wr(fa(7'd5), 32'h80);
    wr(off_acc, 32'h80);
    ex({opc_add_acc_to_file, 1'b0, 7'd5});
    rdc(off_acc, 32'h00);
    rdc(fa(7'd5), 32'h80);
    st(3'b101);
    wr(off_acc, 32'h22);
    wr(fa(7'd5), 32'h1e);
    ex({opc_add_acc_to_file, 1'b1, 7'd5});
    rdc(fa(7'd5), 32'h40);
    rdc(off_acc, 32'h22);
    st(3'b010);
    $display("add test done");
    wr(off_status, 32'h3);
    wr(off_acc, 32'hf0);
    ex({opc_and_immediate, 8'h0f});
    rdc(off_acc, 32'h0);
    st(3'b111);
    wr(fa(7'd6), 32'haa);
    wr(off_acc, 32'h0f);
    ex({opc_and_acc_with_file, 1'b1, 7'd6});
    rdc(fa(7'd6), 32'h0a);
    rdc(off_acc, 32'h0f);
    st(3'b011);
    ex({opc_and_acc_with_file, 1'b0, 7'd6});
    rdc(off_acc, 32'h0a);
    $display("and test done");
    wr(fa(7'd9), 32'h0);
    v = 8'h00;
    for (int i = 0; i < 8; i++) begin
      ex({opc_bit_set, 3'(i), 7'd9});
      v[i] = 1'b1;
      rdc(fa(7'd9), {24'h0, v});
    end
    for (int i = 0; i < 8; i++) begin
      ex({opc_bit_clear, 3'(i), 7'd9});
      v[i] = 1'b0;
      rdc(fa(7'd9), {24'h0, v});
    end
    st(3'b011);
    $display("bit test done");
    wr(fa(7'd9), 32'h81);
    for (int i = 0; i < 4; i++) begin
      wr(off_acc, 32'h0);
      wr(off_pc, 32'h100);
      ex({(i < 2) ? opc_skip_if_bit_one : opc_skip_if_bit_zero, bsel[i], 7'd9});
      apb(1'b0, off_status, 32'h0);
      check({31'h0, rd[status_skip_bit]}, {31'h0, skp[i]});
      ex({opc_add_immediate, 1'b0, 8'h01});
      rdc(off_acc, {31'h0, ~skp[i]});
      rdc(off_pc, 32'h102);
    end
    $display("skip test done");
    wr(off_pc, 32'h0123);
    wr(off_page_latch, 32'h18);
    ex({opc_call, 11'h7ff});
    rdc(off_pc, 32'h1fff);
    rdc(off_stack_top, 32'h0001_0124);
    wr(off_page_latch, 32'h10);
    wr(off_acc, 32'h0);
    ex({opc_call, 11'h005});
    ex({opc_add_immediate, 1'b0, 8'h02});
    rdc(off_acc, 32'h2);
    rdc(off_stack_top, 32'h0002_0000);
    rdc(off_pc, 32'h1006);
    $display("call test done");
    ex(14'h0000);
    rdc(off_status, 32'h0000_0400);
    rdc(off_pc, 32'h1007);
    wr(off_status, 32'h0000_0400);
    rdc(off_status, 32'h0);
    $display("unsupported test done");
    apb(1'b1, 12'h100, 32'hffff_ffff);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h100, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    rdc(off_acc, 32'h2);
    $display("unmapped test done");
    give_verdict();
  end
endmodule : instr_exec_test
